/* File: loop_dac_pkg.sv */
// Shared constants and carrier types for the current-loop DAC serial input logic.
// Assumes a core clock of 200 MHz and a serial clock pin that the host drives.
package loop_dac_pkg;

   // Word geometry
   localparam int WORD_BITS  = 16;
   localparam int FIFO_DEPTH = 16;

   // Asynchronous framing: serial clocks per data bit and sampling points
   localparam int         OVERSAMPLE     = 16;
   localparam logic [3:0] BIT_LAST       = 4'hF;
   localparam logic [3:0] HALF_BIT_LAST  = 4'h7;
   localparam logic [4:0] DATA_BITS_LAST = 5'h0F;
   localparam logic [4:0] ERR_PULSE_LEN  = 5'h10;

   // Values after reset
   localparam logic [WORD_BITS-1:0] CODE_MIN    = 16'h0000;
   localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;

   typedef logic [WORD_BITS-1:0] word_type;

   typedef enum logic [2:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP,
      RX_BREAK
   } rx_state_type;

   // State of the logic clocked by the serial clock pin
   typedef struct packed {
      logic         data_s1;
      logic         data_s2;
      logic         latch_s1;
      logic         latch_s2;
      word_type     shreg;
      logic         data_out;
      logic         async_seen;
      rx_state_type rx_state;
      logic [3:0]   rx_cnt;
      logic [4:0]   rx_bits;
      word_type     rx_word;
      logic [4:0]   err_cnt;
      logic         push_valid;
      word_type     push_word;
   } link_state_type;

   // State of the logic clocked by the core clock
   typedef struct packed {
      logic     latch_s1;
      logic     latch_s2;
      logic     latch_prev;
      logic     clear_s1;
      logic     clear_s2;
      logic     near_s1;
      logic     near_s2;
      logic     shared_s1;
      logic     shared_s2;
      word_type held;
      word_type dac;
      logic     load_done;
      logic     fault_oe;
      logic     fault_seen;
   } core_state_type;

endpackage : loop_dac_pkg

/* File: word_fifo.sv */
// Dual-clock word FIFO with gray-coded pointers.
// Assumes each side has its own synchronous reset, released in its own domain.
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Filling side
   input  wire  logic             wr_clk,
   input  wire  logic             wr_reset,
   input  wire  logic             wr_valid,
   output logic                   wr_ready,
   input  wire  logic [WIDTH-1:0] wr_data,
   // Draining side
   input  wire  logic             rd_clk,
   input  wire  logic             rd_reset,
   output logic                   rd_valid,
   input  wire  logic             rd_ready,
   output logic [WIDTH-1:0]       rd_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] other_s1;
      logic [AW:0] other_s2;
   } side_type;

   side_type         w;
   side_type         next_w;
   side_type         r;
   side_type         next_r;
   logic [WIDTH-1:0] mem [DEPTH];

   // Full when the write pointer is one lap ahead of the synced read pointer
   assign wr_ready = (w.gray != {~w.other_s2[AW:AW-1], w.other_s2[AW-2:0]});
   assign rd_valid = (r.gray != r.other_s2);
   assign rd_data  = mem[r.bin[AW-1:0]];

   always_comb begin
      next_w          = w;
      next_w.other_s1 = r.gray;
      next_w.other_s2 = w.other_s1;
      if (wr_valid && wr_ready) begin
         next_w.bin = w.bin + 1'h1;
      end
      next_w.gray = (next_w.bin >> 1) ^ next_w.bin;
   end

   always_ff @(posedge wr_clk) begin
      if (wr_reset) begin
         w <= '0;
      end else begin
         w <= next_w;
      end
   end

   // Storage carries no reset; only the pointers decide what is valid
   always_ff @(posedge wr_clk) begin
      if (wr_valid && wr_ready) begin
         mem[w.bin[AW-1:0]] <= wr_data;
      end
   end

   always_comb begin
      next_r          = r;
      next_r.other_s1 = w.gray;
      next_r.other_s2 = r.other_s1;
      if (rd_valid && rd_ready) begin
         next_r.bin = r.bin + 1'h1;
      end
      next_r.gray = (next_r.bin >> 1) ^ next_r.bin;
   end

   always_ff @(posedge rd_clk) begin
      if (rd_reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule : word_fifo

`default_nettype wire

/* File: loop_dac_serial_input.sv */
// Digital input logic of a 16-bit current-loop DAC: three-wire shift and
// latch path, asynchronous framed path, daisy-chain output and loop fault pin.
// Assumes SERIAL_CLK comes from the host and may stop outside transfers,
// CLK is a free-running 200 MHz core clock, and CLEAR / COMPLIANCE_NEAR are
// levels from outside both domains.
`timescale 1ns/10ps
`default_nettype none

// How it works
// (R1) Shift data in on each serial clock rise
// (R2) Strobe loads parallel latch and DAC code
// (R3) Host keeps serial clock still during load
// (R4) Sixteen-bit shifter; oldest bit leaves on output
// (R5) Two-device chain takes 32 bits, far first
// (R6) Latch tied high selects framed mode
// (R7) Start/stop framed word triggers internal load
// (R8) Fault output active low, open drain
// (R9) Sixteen-bit code, zero is range minimum
// (R10) Latch rising edge loads shifter into DAC
// (R11) Framed mode: sixteen clocks per bit
// (R12) Bad stop bit gives pulse on output
// (R13) Clear forces minimum, keeps latch contents
// (R14) Words travel most significant bit first
module loop_dac_serial_input #(
   parameter int WORD_BITS  = loop_dac_pkg::WORD_BITS,
   parameter int FIFO_DEPTH = loop_dac_pkg::FIFO_DEPTH
) (
   // Core clock and reset
   input  wire  logic                 CLK,
   input  wire  logic                 RESET,
   // Serial link pins
   input  wire  logic                 SERIAL_CLK,
   input  wire  logic                 DATA_IN,
   input  wire  logic                 LATCH,
   output logic                       DATA_OUT,
   // Forced minimum
   input  wire  logic                 CLEAR,
   // Loop fault, open drain
   input  wire  logic                 COMPLIANCE_NEAR,
   input  wire  logic                 FAULT_N_IN,
   output logic                       FAULT_N_OUT,
   output logic                       FAULT_N_OE,
   output logic                       FAULT_SEEN,
   // Converter side
   output logic [WORD_BITS-1:0]       DAC_CODE,
   output logic [WORD_BITS-1:0]       HELD_WORD,
   output logic                       DAC_LOAD
);

   loop_dac_pkg::link_state_type link;
   loop_dac_pkg::link_state_type next_link;
   loop_dac_pkg::core_state_type core;
   loop_dac_pkg::core_state_type next_core;

   logic                         link_rst_s1;
   logic                         link_rst;
   logic                         fifo_wr_ready;
   logic                         fifo_rd_valid;
   logic                         fifo_rd_ready;
   loop_dac_pkg::word_type       fifo_rd_data;
   logic                         latch_rise;
   logic                         rx_bit;

   // Link-side reset follows RESET only while the serial clock runs; a
   // stopped link clock simply holds its state until the next transfer.
   always_ff @(posedge SERIAL_CLK) begin
      link_rst_s1 <= RESET;
      link_rst    <= link_rst_s1;
   end

   // Framed words cross into the core domain through the dual-clock FIFO
   word_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) frame_fifo (
      .wr_clk   (SERIAL_CLK),
      .wr_reset (link_rst),
      .wr_valid (link.push_valid),
      .wr_ready (fifo_wr_ready),
      .wr_data  (link.push_word),
      .rd_clk   (CLK),
      .rd_reset (RESET),
      .rd_valid (fifo_rd_valid),
      .rd_ready (fifo_rd_ready),
      .rd_data  (fifo_rd_data)
   );

   // Link domain
   assign rx_bit = link.data_s2;

   always_comb begin
      next_link = link;

      next_link.data_s1  = DATA_IN;
      next_link.data_s2  = link.data_s1;
      next_link.latch_s1 = LATCH;
      next_link.latch_s2 = link.latch_s1;

      // In three-wire mode DATA_IN belongs to this clock, so it is taken
      // straight into the shifter; the newest bit lands at the bottom.
      next_link.shreg = {link.shreg[WORD_BITS-2:0], DATA_IN}; // [R1] [R4] [R14]

      // Word waits for FIFO room; the next good frame replaces it silently if room never comes
      if (link.push_valid && fifo_wr_ready) begin
         next_link.push_valid = 1'h0;
      end

      if (link.err_cnt != 5'h00) begin
         next_link.err_cnt = link.err_cnt - 5'h01;
      end

      case (link.rx_state)
         loop_dac_pkg::RX_IDLE: begin
            if (!rx_bit) begin
               next_link.rx_state = loop_dac_pkg::RX_START;
               next_link.rx_cnt   = 4'h0;
            end
         end
         loop_dac_pkg::RX_START: begin
            next_link.rx_cnt = link.rx_cnt + 4'h1;
            // Recheck the start bit at its middle to reject glitches
            if (link.rx_cnt == loop_dac_pkg::HALF_BIT_LAST) begin // [R11]
               next_link.rx_cnt  = 4'h0;
               next_link.rx_bits = 5'h00;
               if (!rx_bit) begin
                  next_link.rx_state = loop_dac_pkg::RX_DATA;
               end else begin
                  next_link.rx_state = loop_dac_pkg::RX_IDLE;
               end
            end
         end
         loop_dac_pkg::RX_DATA: begin
            next_link.rx_cnt = link.rx_cnt + 4'h1;
            if (link.rx_cnt == loop_dac_pkg::BIT_LAST) begin // [R11]
               next_link.rx_word = {link.rx_word[WORD_BITS-2:0], rx_bit}; // [R14]
               next_link.rx_bits = link.rx_bits + 5'h01;
               if (link.rx_bits == loop_dac_pkg::DATA_BITS_LAST) begin
                  next_link.rx_state = loop_dac_pkg::RX_STOP;
               end
            end
         end
         loop_dac_pkg::RX_STOP: begin
            next_link.rx_cnt = link.rx_cnt + 4'h1;
            if (link.rx_cnt == loop_dac_pkg::BIT_LAST) begin
               next_link.async_seen = 1'h1; // [R6]
               if (rx_bit) begin
                  // A good frame acts as the internal load strobe
                  next_link.push_valid = 1'h1; // [R7]
                  next_link.push_word  = link.rx_word;
                  next_link.rx_state   = loop_dac_pkg::RX_IDLE;
               end else begin
                  next_link.err_cnt  = loop_dac_pkg::ERR_PULSE_LEN; // [R12]
                  next_link.rx_state = loop_dac_pkg::RX_BREAK;
               end
            end
         end
         loop_dac_pkg::RX_BREAK: begin
            // Wait for the line to idle so a held-low line is not a start
            if (rx_bit) begin
               next_link.rx_state = loop_dac_pkg::RX_IDLE;
            end
         end
         default: begin
            next_link.rx_state = loop_dac_pkg::RX_IDLE;
         end
      endcase

      // A low strobe means three-wire mode: the framer stands down. Framed
      // mode is only claimed after a whole frame, so the first edges of a
      // three-wire transfer never disturb the daisy-chain output.
      if (!link.latch_s2) begin // [R6]
         next_link.rx_state   = loop_dac_pkg::RX_IDLE;
         next_link.async_seen = 1'h0;
      end

      if (next_link.async_seen) begin
         next_link.data_out = (next_link.err_cnt != 5'h00); // [R12]
      end else begin
         next_link.data_out = next_link.shreg[WORD_BITS-1]; // [R4] [R5]
      end
   end

   always_ff @(posedge SERIAL_CLK) begin
      if (link_rst) begin
         link.data_s1    <= 1'h1;
         link.data_s2    <= 1'h1;
         link.latch_s1   <= 1'h1;
         link.latch_s2   <= 1'h1;
         link.shreg      <= loop_dac_pkg::SHIFT_RESET;
         link.data_out   <= 1'h0;
         link.async_seen <= 1'h0;
         link.rx_state   <= loop_dac_pkg::RX_IDLE;
         link.rx_cnt     <= 4'h0;
         link.rx_bits    <= 5'h00;
         link.rx_word    <= loop_dac_pkg::SHIFT_RESET;
         link.err_cnt    <= 5'h00;
         link.push_valid <= 1'h0;
         link.push_word  <= loop_dac_pkg::SHIFT_RESET;
      end else begin
         link <= next_link;
      end
   end

   // Core domain
   assign latch_rise = core.latch_s2 && !core.latch_prev;

   // Queued frames wait while the output is forced to minimum
   assign fifo_rd_ready = !core.clear_s2;

   always_comb begin
      next_core = core;

      next_core.latch_s1   = LATCH;
      next_core.latch_s2   = core.latch_s1;
      next_core.latch_prev = core.latch_s2;
      next_core.clear_s1   = CLEAR;
      next_core.clear_s2   = core.clear_s1;
      next_core.near_s1    = COMPLIANCE_NEAR;
      next_core.near_s2    = core.near_s1;
      next_core.shared_s1  = FAULT_N_IN;
      next_core.shared_s2  = core.shared_s1;
      next_core.load_done  = 1'h0;

      if (latch_rise) begin
         // The shifter is quiet here because the host holds its clock
         // still while loading, so the word is sampled whole.
         next_core.held      = link.shreg; // [R2] [R3] [R10]
         next_core.dac       = link.shreg; // [R2] [R10]
         next_core.load_done = 1'h1;
      end else if (fifo_rd_valid && fifo_rd_ready) begin
         next_core.held      = fifo_rd_data; // [R7]
         next_core.dac       = fifo_rd_data; // [R7]
         next_core.load_done = 1'h1;
      end

      // Clear wins over any load and leaves the held word alone; the code
      // stays at minimum after release until the next load.
      if (core.clear_s2) begin
         next_core.dac = loop_dac_pkg::CODE_MIN; // [R13] [R9]
      end

      // Pin is only ever pulled low; several devices share one pull-up
      next_core.fault_oe   = core.near_s2; // [R8]
      next_core.fault_seen = !core.shared_s2;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         core.latch_s1   <= 1'h1;
         core.latch_s2   <= 1'h1;
         core.latch_prev <= 1'h1;
         core.clear_s1   <= 1'h0;
         core.clear_s2   <= 1'h0;
         core.near_s1    <= 1'h0;
         core.near_s2    <= 1'h0;
         core.shared_s1  <= 1'h1;
         core.shared_s2  <= 1'h1;
         core.held       <= loop_dac_pkg::SHIFT_RESET;
         core.dac        <= loop_dac_pkg::CODE_MIN; // [R9]
         core.load_done  <= 1'h0;
         core.fault_oe   <= 1'h0;
         core.fault_seen <= 1'h0;
      end else begin
         core <= next_core;
      end
   end

   // Output data level of the open-drain pin is held low by a register that loads zero on every core clock edge
   logic fault_level;

   always_ff @(posedge CLK) begin
      fault_level <= 1'h0; // [R8]
   end

   assign DATA_OUT    = link.data_out;
   assign FAULT_N_OUT = fault_level;
   assign FAULT_N_OE  = core.fault_oe;
   assign FAULT_SEEN  = core.fault_seen;
   assign DAC_CODE    = core.dac;
   assign HELD_WORD   = core.held;
   assign DAC_LOAD    = core.load_done;

endmodule : loop_dac_serial_input

`default_nettype wire

/* File: loop_dac_serial_input_monitor.sv */
// Checker for the serial input logic: load timing, clear, fault pin, chain.
// Assumes it is bound onto loop_dac_serial_input and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module loop_dac_serial_input_monitor #(
   parameter int WORD_BITS  = 16,
   parameter int FIFO_DEPTH = 16
) (
   // Clocks and reset
   input wire logic                 CLK,
   input wire logic                 RESET,
   input wire logic                 SERIAL_CLK,
   // Link pins
   input wire logic                 DATA_IN,
   input wire logic                 LATCH,
   input wire logic                 DATA_OUT,
   // Clear and fault
   input wire logic                 CLEAR,
   input wire logic                 COMPLIANCE_NEAR,
   input wire logic                 FAULT_N_OUT,
   input wire logic                 FAULT_N_OE,
   // Converter side
   input wire logic [WORD_BITS-1:0] DAC_CODE,
   input wire logic                 DAC_LOAD
);
   // Link edges since the latch pin last changed level, saturating
   logic [8:0] lo_cnt;
   logic [8:0] hi_cnt;
   always_ff @(posedge SERIAL_CLK) begin
      lo_cnt <= (LATCH || RESET) ? 9'h000 : lo_cnt + {8'h00, lo_cnt < 9'h014};
      hi_cnt <= (!LATCH || RESET) ? 9'h000 : hi_cnt + {8'h00, hi_cnt < 9'h190};
   end

   sequence s_load_seen;
      ##[3:4] DAC_LOAD;
   endsequence
   sequence s_half_pulse;
      DATA_OUT [*8];
   endsequence

   property p_load_lat;
      @(posedge CLK) disable iff (RESET) $rose(LATCH) |-> s_load_seen;
   endproperty
   a_load_lat: assert property (p_load_lat) else $error("no load after latch rise");
   property p_pulse;
      @(posedge CLK) disable iff (RESET) DAC_LOAD |=> !DAC_LOAD;
   endproperty
   a_pulse: assert property (p_pulse) else $error("load pulse too long");
   property p_code_chg;
      @(posedge CLK) disable iff (RESET) $changed(DAC_CODE) |-> DAC_LOAD || DAC_CODE == '0;
   endproperty
   a_code_chg: assert property (p_code_chg) else $error("code moved without load");
   property p_clear;
      @(posedge CLK) disable iff (RESET) CLEAR [*5] |-> DAC_CODE == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not force minimum");
   property p_fault_on;
      @(posedge CLK) disable iff (RESET) COMPLIANCE_NEAR [*4] |-> FAULT_N_OE && !FAULT_N_OUT;
   endproperty
   a_fault_on: assert property (p_fault_on) else $error("fault not pulled low");
   property p_fault_off;
      @(posedge CLK) disable iff (RESET) !COMPLIANCE_NEAR [*4] |-> !FAULT_N_OE;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault held without cause");
   property p_chain;
      @(posedge SERIAL_CLK) disable iff (RESET) lo_cnt == 9'h014 |-> DATA_OUT == $past(DATA_IN, 16);
   endproperty
   a_chain: assert property (p_chain) else $error("chain output wrong");
   property p_ferr;
      @(posedge SERIAL_CLK) disable iff (RESET)
         hi_cnt == 9'h190 && $rose(DATA_OUT) |-> s_half_pulse ##1 s_half_pulse ##1 !DATA_OUT;
   endproperty
   a_ferr: assert property (p_ferr) else $error("framing error pulse length");
endmodule : loop_dac_serial_input_monitor

bind loop_dac_serial_input loop_dac_serial_input_monitor #(
   .WORD_BITS(WORD_BITS), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
   .CLK(CLK), .RESET(RESET), .SERIAL_CLK(SERIAL_CLK), .DATA_IN(DATA_IN), .LATCH(LATCH),
   .DATA_OUT(DATA_OUT), .CLEAR(CLEAR), .COMPLIANCE_NEAR(COMPLIANCE_NEAR),
   .FAULT_N_OUT(FAULT_N_OUT), .FAULT_N_OE(FAULT_N_OE), .DAC_CODE(DAC_CODE),
   .DAC_LOAD(DAC_LOAD));
`default_nettype wire

/* File: serial_host_model.sv */
// Serial host model: three-wire words, latch strobe and framed words.
// Assumes the bench calls its tasks one at a time; the link clock idles low.
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
   // Link pins towards the device
   output var logic serial_clk,
   output var logic data_in,
   output var logic latch
);
   initial begin
      serial_clk = 1'b0;
      data_in = 1'b1;
      latch = 1'b0;
   end

   // Clock runs only inside transfers, 80 ns period
   task automatic tick(input int n);
      repeat (n) begin
         #40 serial_clk = 1'b1;
         #40 serial_clk = 1'b0;
      end
   endtask : tick

   task automatic shift_word(input loop_dac_pkg::word_type w);
      for (int i = 15; i >= 0; i--) begin
         data_in = w[i];
         tick(1);
      end
      // Stale data is not left on the line after the word
      data_in = ~data_in;
   endtask : shift_word

   task automatic strobe();
      latch = 1'b1;
      #100;
      latch = 1'b0;
      #50;
   endtask : strobe

   task automatic set_latch(input logic v);
      // The line idles high before framing, else a stale low reads as a start bit
      data_in = 1'b1;
      latch = v;
   endtask : set_latch

   task automatic frame(input loop_dac_pkg::word_type w, input logic stop);
      data_in = 1'b0;
      tick(16);
      for (int i = 15; i >= 0; i--) begin
         data_in = w[i];
         tick(16);
      end
      data_in = stop;
      tick(16);
      data_in = 1'b1;
   endtask : frame
endmodule : serial_host_model
`default_nettype wire

/* File: loop_dac_serial_input_test.sv */
// Testbench for the serial input logic: word loads, clear, chain, fault, framed mode.
// Assumes serial_host_model drives the link pins and the checker is bound.
`timescale 1ns/10ps
`default_nettype none

module loop_dac_serial_input_test;
   typedef struct {
      loop_dac_pkg::word_type word;
      logic                   clear;
      loop_dac_pkg::word_type code;
   } row_type;

   logic                   CLK;
   logic                   RESET;
   logic                   CLEAR;
   logic                   COMPLIANCE_NEAR;
   logic                   other_pull;
   wire logic              SERIAL_CLK;
   wire logic              DATA_IN;
   wire logic              LATCH;
   wire logic              FAULT_N_IN;
   logic                   DATA_OUT;
   logic                   FAULT_N_OUT;
   logic                   FAULT_N_OE;
   logic                   FAULT_SEEN;
   logic                   DAC_LOAD;
   loop_dac_pkg::word_type DAC_CODE;
   loop_dac_pkg::word_type HELD_WORD;
   int                     n_errors = 0;
   int                     checked = 0;
   int                     n_loads = 0;
   int                     base;
   row_type rows [5] = '{'{16'h0000, 1'b0, 16'h0000}, '{16'hFFFF, 1'b0, 16'hFFFF},
      '{16'h8001, 1'b0, 16'h8001}, '{16'h1234, 1'b1, 16'h0000}, '{16'hA5C3, 1'b0, 16'hA5C3}};

   // Shared open-drain fault wire with pull-up and a second device
   assign FAULT_N_IN = !((FAULT_N_OE && !FAULT_N_OUT) || other_pull);

   serial_host_model u_host (.serial_clk(SERIAL_CLK), .data_in(DATA_IN), .latch(LATCH));

   loop_dac_serial_input u_dut (
      .CLK(CLK), .RESET(RESET), .SERIAL_CLK(SERIAL_CLK), .DATA_IN(DATA_IN), .LATCH(LATCH),
      .DATA_OUT(DATA_OUT), .CLEAR(CLEAR), .COMPLIANCE_NEAR(COMPLIANCE_NEAR),
      .FAULT_N_IN(FAULT_N_IN), .FAULT_N_OUT(FAULT_N_OUT), .FAULT_N_OE(FAULT_N_OE),
      .FAULT_SEEN(FAULT_SEEN), .DAC_CODE(DAC_CODE), .HELD_WORD(HELD_WORD),
      .DAC_LOAD(DAC_LOAD));

   initial CLK = 1'b0;
   always #2.5 CLK = ~CLK;

   always @(posedge CLK) begin
      if (DAC_LOAD === 1'b1)
         n_loads++;
   end

   task automatic check_word(input loop_dac_pkg::word_type got, exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t word %h want %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_bit(input logic got, exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bit %b want %b", $time, got, exp);
      end
   endtask : check_bit

   task automatic wait_clk(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : wait_clk

   task automatic wrap_up();
      $display("counts: %0d checks, %0d errors", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   initial begin
      #300000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      RESET = 1'b1;
      CLEAR = 1'b0;
      COMPLIANCE_NEAR = 1'b0;
      other_pull = 1'b0;
      // Link side resets only while its clock runs
      u_host.tick(4);
      wait_clk(5);
      RESET = 1'b0;
      wait_clk(4);
      check_word(DAC_CODE, 16'h0000);
      check_word(HELD_WORD, 16'h0000);
      check_bit(FAULT_N_OE, 1'b0);
      $display("test reset done");
      foreach (rows[i]) begin
         CLEAR = rows[i].clear;
         base = n_loads;
         u_host.shift_word(rows[i].word);
         u_host.strobe();
         wait_clk(8);
         check_word(DAC_CODE, rows[i].code);
         check_word(HELD_WORD, rows[i].word);
         check_word(16'(n_loads - base), 16'h0001);
         CLEAR = 1'b0;
         wait_clk(8);
         check_word(DAC_CODE, rows[i].code);
         $display("test row %0d done", i);
      end
      u_host.shift_word(16'h5A0F);
      u_host.shift_word(16'hBC71);
      wait_clk(1);
      check_bit(DATA_OUT, 1'b1);
      u_host.strobe();
      wait_clk(8);
      check_word(DAC_CODE, 16'hBC71);
      $display("test chain done");
      COMPLIANCE_NEAR = 1'b1;
      wait_clk(6);
      check_bit(FAULT_N_OE, 1'b1);
      check_bit(FAULT_N_OUT, 1'b0);
      check_bit(FAULT_SEEN, 1'b1);
      COMPLIANCE_NEAR = 1'b0;
      other_pull = 1'b1;
      wait_clk(6);
      check_bit(FAULT_N_OE, 1'b0);
      check_bit(FAULT_SEEN, 1'b1);
      other_pull = 1'b0;
      wait_clk(6);
      check_bit(FAULT_SEEN, 1'b0);
      $display("test fault done");
      u_host.set_latch(1'b1);
      u_host.tick(40);
      u_host.frame(16'h2468, 1'b1);
      u_host.frame(16'h9BDF, 1'b1);
      u_host.tick(20);
      wait_clk(20);
      check_word(DAC_CODE, 16'h9BDF);
      u_host.frame(16'h0F0F, 1'b0);
      check_bit(DATA_OUT, 1'b1);
      u_host.tick(40);
      wait_clk(20);
      check_word(DAC_CODE, 16'h9BDF);
      check_bit(DATA_OUT, 1'b0);
      $display("test framed done");
      // Reset in mid-run with the strobe still tied high: no load may follow
      RESET = 1'b1;
      u_host.tick(4);
      RESET = 1'b0;
      base = n_loads;
      wait_clk(8);
      check_word(DAC_CODE, 16'h0000);
      check_word(HELD_WORD, 16'h0000);
      check_bit(DATA_OUT, 1'b0);
      check_word(16'(n_loads - base), 16'h0000);
      u_host.tick(40);
      u_host.frame(16'h3C5A, 1'b1);
      u_host.tick(20);
      wait_clk(20);
      check_word(DAC_CODE, 16'h3C5A);
      check_word(16'(n_loads - base), 16'h0001);
      $display("test mid reset done");
      wrap_up();
   end
endmodule : loop_dac_serial_input_test
`default_nettype wire
